/* File: hw/bmss_sequencer.sv */
// Boot mode secure sequencer: strap latch, two-pass boot control and secure register gate.
// Assumes rstn is the power-on reset and software drives the plain register port.
`timescale 1ns/1ns
`default_nettype none

module bmss_sequencer #(
  parameter int SELF_RESET_CYCLES = bmss_pkg::SELF_RESET_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2:0] powerUpStrapBits,
  input wire logic [7:0] address,
  input wire logic [31:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [31:0] readData,
  output logic cpuResetn,
  output logic initBootActive,
  output logic secureOpen,
  output logic appRunning,
  output logic serialLoadActive,
  output logic secureViolation,
  output logic [7:0] cpuMasterId,
  output logic [7:0] dmaMasterId,
  output logic jtagFourWireEn,
  output logic swdTwoWireEn,
  output logic uartLoadEn
);

  // The self-reset counter must hold the pulse length.
  if (SELF_RESET_CYCLES < 1 || SELF_RESET_CYCLES > 255) begin : g_bad_len
    $error("SELF_RESET_CYCLES must lie between 1 and 255");
  end

  // Last cycle of the self-reset pulse, counted from the cycle it starts.
  localparam int RstLast = SELF_RESET_CYCLES - 1;

  logic [2:0] strapLatched;
  logic strapValid;
  bmss_pkg::bmss_mode_t mode;

  bmss_pkg::bmss_state_t state, next_state;
  logic [7:0] count, next_count;
  logic initFlag, next_initFlag;
  logic [7:0] appCpuId, next_appCpuId;
  logic [7:0] appDmaId, next_appDmaId;
  logic [31:0] scratch, next_scratch;
  logic [15:0] blockedCount, next_blockedCount;
  logic next_secureViolation;
  logic next_cpuResetn;
  logic [7:0] next_cpuMasterId, next_dmaMasterId;
  logic ctrlWrite, secureAccess, secureBlocked;
  logic [31:0] statusWord, next_readData;

  // strap latch instance.
  // Holds the power-up strap value for the whole power cycle.
  bmss_strap_latch u_strap (
    .clock(clock),
    .rstn(rstn),
    .powerUpStrapBits(powerUpStrapBits),
    .strapLatched(strapLatched),
    .strapValid(strapValid)
  );

  assign mode = bmss_pkg::decode_mode(strapLatched);

  // Access decode of the register port.
  assign ctrlWrite = writeStrobe && (address == bmss_pkg::REG_CONTROL);
  assign secureAccess = (writeStrobe || readStrobe) && bmss_pkg::is_secure(address);
  assign secureBlocked = secureAccess && !secureOpen;

  // Next values of the boot sequence and the secure registers.
  always_comb begin
    next_state = state;
    next_count = count;
    next_initFlag = initFlag;
    next_appCpuId = appCpuId;
    next_appDmaId = appDmaId;
    next_scratch = scratch;
    next_blockedCount = blockedCount;
    next_secureViolation = 1'b0;
    case (state)
      bmss_pkg::ST_POR_HOLD: begin
        if (strapValid) begin
          next_state = bmss_pkg::ST_ROM_ENTRY;
        end
      end
      bmss_pkg::ST_ROM_ENTRY: begin
        if (initFlag) begin
          next_state = bmss_pkg::ST_INIT_BOOT;
        end else if (mode == bmss_pkg::serial_load_mode) begin
          next_state = bmss_pkg::ST_SERIAL_LOAD;
        end else begin
          next_state = bmss_pkg::ST_UNSECURE_BOOT;
        end
      end
      bmss_pkg::ST_INIT_BOOT: begin
        if (ctrlWrite && writeData[bmss_pkg::CTRL_SELF_RESET_BIT]) begin
          next_initFlag = 1'b0;
          next_state = bmss_pkg::ST_SELF_RESET;
          next_count = 8'(SELF_RESET_CYCLES - 1);
        end
      end
      bmss_pkg::ST_SELF_RESET: begin
        if (count == 8'h00) begin
          next_state = bmss_pkg::ST_ROM_ENTRY;
        end else begin
          next_count = count - 8'h01;
        end
      end
      bmss_pkg::ST_UNSECURE_BOOT: begin
        if (ctrlWrite && writeData[bmss_pkg::CTRL_BOOT_DONE_BIT]) begin
          next_state = bmss_pkg::ST_APP_RUN;
        end
      end
      bmss_pkg::ST_APP_RUN: begin
        next_state = bmss_pkg::ST_APP_RUN;
      end
      bmss_pkg::ST_SERIAL_LOAD: begin
        next_state = bmss_pkg::ST_SERIAL_LOAD;
      end
      default: begin
        next_state = bmss_pkg::ST_POR_HOLD;
      end
    endcase
    if (writeStrobe && bmss_pkg::is_secure(address) && secureOpen) begin
      case (address)
        bmss_pkg::REG_INIT_FLAG: begin
          if (!writeData[0]) begin
            next_initFlag = 1'b0;
          end
        end
        bmss_pkg::REG_CPU_ID: begin
          next_appCpuId = writeData[7:0];
        end
        bmss_pkg::REG_DMA_ID: begin
          next_appDmaId = writeData[7:0];
        end
        bmss_pkg::REG_SCRATCH: begin
          next_scratch = writeData;
        end
        default: begin
          next_scratch = scratch;
        end
      endcase
    end
    if (secureBlocked) begin
      next_secureViolation = 1'b1;
      if (blockedCount != 16'hFFFF) begin
        next_blockedCount = blockedCount + 16'h0001;
      end
    end
  end

  // Next values of the outputs that follow the sequence.
  always_comb begin
    next_cpuResetn = (next_state != bmss_pkg::ST_POR_HOLD) && (next_state != bmss_pkg::ST_SELF_RESET);
    next_cpuMasterId = next_initFlag ? bmss_pkg::INIT_CPU_ID : next_appCpuId;
    next_dmaMasterId = next_initFlag ? bmss_pkg::INIT_DMA_ID : next_appDmaId;
  end

  // Registers of the boot sequence; the flag comes up set out of power-on reset.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= bmss_pkg::ST_POR_HOLD;
      count <= 8'h00;
      initFlag <= 1'b1;
      appCpuId <= bmss_pkg::APP_CPU_ID_RESET;
      appDmaId <= bmss_pkg::APP_DMA_ID_RESET;
      scratch <= 32'h0000_0000;
      blockedCount <= 16'h0000;
      secureViolation <= 1'b0;
      cpuResetn <= 1'b0;
      initBootActive <= 1'b0;
      secureOpen <= 1'b0;
      appRunning <= 1'b0;
      serialLoadActive <= 1'b0;
      cpuMasterId <= bmss_pkg::INIT_CPU_ID;
      dmaMasterId <= bmss_pkg::INIT_DMA_ID;
    end else begin
      state <= next_state;
      count <= next_count;
      initFlag <= next_initFlag;
      appCpuId <= next_appCpuId;
      appDmaId <= next_appDmaId;
      scratch <= next_scratch;
      blockedCount <= next_blockedCount;
      secureViolation <= next_secureViolation;
      cpuResetn <= next_cpuResetn;
      initBootActive <= (next_state == bmss_pkg::ST_INIT_BOOT);
      secureOpen <= (next_state == bmss_pkg::ST_INIT_BOOT);
      appRunning <= (next_state == bmss_pkg::ST_APP_RUN);
      serialLoadActive <= (next_state == bmss_pkg::ST_SERIAL_LOAD);
      cpuMasterId <= next_cpuMasterId;
      dmaMasterId <= next_dmaMasterId;
    end
  end

  // Pin mapping registers, steady once the strap is latched.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      jtagFourWireEn <= 1'b0;
      swdTwoWireEn <= 1'b0;
      uartLoadEn <= 1'b0;
    end else begin
      jtagFourWireEn <= strapValid && (mode != bmss_pkg::func_two_wire_debug_mode);
      swdTwoWireEn <= strapValid && (mode == bmss_pkg::func_two_wire_debug_mode);
      uartLoadEn <= strapValid && (mode == bmss_pkg::serial_load_mode);
    end
  end

  // Status word assembly.
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[bmss_pkg::STAT_STRAP_LSB +: 3] = strapLatched;
    statusWord[bmss_pkg::STAT_STATE_LSB +: 4] = 4'(state);
    statusWord[bmss_pkg::STAT_FLAG_BIT] = initFlag;
    statusWord[bmss_pkg::STAT_SECURE_BIT] = secureOpen;
    statusWord[bmss_pkg::STAT_STRAP_VALID_BIT] = strapValid;
    statusWord[bmss_pkg::STAT_MODE_LSB +: 2] = mode;
  end

  // Read data for the cycle after a read strobe; blocked or unmapped reads give zero.
  always_comb begin
    next_readData = 32'h0000_0000;
    if (readStrobe && !secureBlocked) begin
      case (address)
        bmss_pkg::REG_STATUS: next_readData = statusWord;
        bmss_pkg::REG_BLOCKED: next_readData = {16'h0000, blockedCount};
        bmss_pkg::REG_INIT_FLAG: next_readData = {31'h0000_0000, initFlag};
        bmss_pkg::REG_CPU_ID: next_readData = {24'h00_0000, appCpuId};
        bmss_pkg::REG_DMA_ID: next_readData = {24'h00_0000, appDmaId};
        bmss_pkg::REG_SCRATCH: next_readData = scratch;
        default: next_readData = 32'h0000_0000;
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readData <= 32'h0000_0000;
    end else begin
      readData <= next_readData;
    end
  end

  // Checks of the sequence against its causes.
  property p_flag_por;
    @(posedge clock) disable iff (!rstn)
    (state == bmss_pkg::ST_POR_HOLD) |-> (initFlag && !cpuResetn);
  endproperty
  a_flag_por: assert property (p_flag_por) else $error("flag not set or processor running before strap latch");

  property p_secure_block;
    @(posedge clock) disable iff (!rstn)
    (writeStrobe && bmss_pkg::is_secure(address) && !secureOpen)
      |=> ($stable(appCpuId) && $stable(appDmaId) && $stable(scratch) && secureViolation);
  endproperty
  a_secure_block: assert property (p_secure_block) else $error("secure write outside init was not blocked");

  property p_init_end;
    @(posedge clock) disable iff (!rstn)
    (state == bmss_pkg::ST_INIT_BOOT && ctrlWrite && writeData[bmss_pkg::CTRL_SELF_RESET_BIT])
      |=> (!initFlag && cpuMasterId == appCpuId && dmaMasterId == appDmaId && !cpuResetn);
  endproperty
  a_init_end: assert property (p_init_end) else $error("init end did not clear flag or switch identifiers");

  property p_self_reset;
    @(posedge clock) disable iff (!rstn)
    $rose(state == bmss_pkg::ST_SELF_RESET)
      |-> (!cpuResetn throughout (##[RstLast:RstLast] 1'b1)) ##1 (state == bmss_pkg::ST_ROM_ENTRY && cpuResetn);
  endproperty
  a_self_reset: assert property (p_self_reset) else $error("self reset pulse length wrong");

  property p_second_boot;
    @(posedge clock) disable iff (!rstn)
    (state == bmss_pkg::ST_ROM_ENTRY && !initFlag)
      |=> (!secureOpen && cpuMasterId == appCpuId)
      ##0 (state == bmss_pkg::ST_UNSECURE_BOOT || state == bmss_pkg::ST_SERIAL_LOAD);
  endproperty
  a_second_boot: assert property (p_second_boot) else $error("second boot did not take the application path");

  property p_app_locked;
    @(posedge clock) disable iff (!rstn)
    (state == bmss_pkg::ST_APP_RUN) |=> (state == bmss_pkg::ST_APP_RUN && !secureOpen && appRunning);
  endproperty
  a_app_locked: assert property (p_app_locked) else $error("application pass left or secure region opened");

  property p_serial_wait;
    @(posedge clock) disable iff (!rstn)
    (state == bmss_pkg::ST_SERIAL_LOAD) |=> (state == bmss_pkg::ST_SERIAL_LOAD && uartLoadEn && jtagFourWireEn);
  endproperty
  a_serial_wait: assert property (p_serial_wait) else $error("serial load left or mapping wrong");

  property p_two_wire;
    @(posedge clock) disable iff (!rstn)
    (strapValid && strapLatched == bmss_pkg::STRAP_TWO_WIRE) |=> (swdTwoWireEn && !jtagFourWireEn && !uartLoadEn);
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("two-wire strap did not map SWD");

  property p_strap_frozen;
    @(posedge clock) disable iff (!rstn)
    strapValid |=> (strapValid && $stable(strapLatched));
  endproperty
  a_strap_frozen: assert property (p_strap_frozen) else $error("strap register changed after latch");

endmodule

`default_nettype wire

/* File: hw/bmss_strap_latch.sv */
// Power-up strap latch of the boot mode secure sequencer.
// Assumes rstn is the power-on reset and the strap pins are steady at its release.
`timescale 1ns/1ns
`default_nettype none

module bmss_strap_latch (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2:0] powerUpStrapBits,
  output logic [2:0] strapLatched,
  output logic strapValid
);

  logic [2:0] next_strapLatched;
  logic next_strapValid;

  // capture once after release.
  // Samples the pins in the first cycle after power-on reset, then freezes.
  always_comb begin
    next_strapLatched = strapLatched;
    next_strapValid = strapValid;
    if (!strapValid) begin
      next_strapLatched = powerUpStrapBits;
      next_strapValid = 1'b1;
    end
  end

  // never resampled.
  // Only power-on reset clears the latch; processor self-reset does not reach it.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strapLatched <= bmss_pkg::STRAP_RESET;
      strapValid <= 1'b0;
    end else begin
      strapLatched <= next_strapLatched;
      strapValid <= next_strapValid;
    end
  end

endmodule

`default_nettype wire

/* File: include/bmss_pkg.sv */
// Shared constants and types of the boot mode secure sequencer.
// Assumes a single 100 MHz clock and a plain register port with byte addresses.
package bmss_pkg;

  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses.
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_BLOCKED = 8'h08;
  localparam logic [7:0] REG_INIT_FLAG = 8'h10;
  localparam logic [7:0] REG_CPU_ID = 8'h14;
  localparam logic [7:0] REG_DMA_ID = 8'h18;
  localparam logic [7:0] REG_SCRATCH = 8'h1C;
  // The secure region spans these addresses inclusive.
  localparam logic [7:0] SECURE_FIRST = 8'h10;
  localparam logic [7:0] SECURE_LAST = 8'h1C;

  // Control register bits.
  localparam int CTRL_SELF_RESET_BIT = 0;
  localparam int CTRL_BOOT_DONE_BIT = 1;
  // Status register fields.
  localparam int STAT_STRAP_LSB = 0;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_FLAG_BIT = 8;
  localparam int STAT_SECURE_BIT = 9;
  localparam int STAT_STRAP_VALID_BIT = 10;
  localparam int STAT_MODE_LSB = 12;

  // Strap encodings, bit 2 down to bit 0.
  localparam int STRAP_W = 3;
  localparam logic [2:0] STRAP_SERIAL_LOAD = 3'h4;
  localparam logic [2:0] STRAP_TWO_WIRE = 3'h1;
  localparam logic [2:0] STRAP_FOUR_WIRE = 3'h0;
  localparam logic [2:0] STRAP_RESET = 3'h0;

  // Bus master identifiers used during the init pass and defaults for the application pass.
  localparam int ID_W = 8;
  localparam logic [7:0] INIT_CPU_ID = 8'h01;
  localparam logic [7:0] INIT_DMA_ID = 8'h02;
  localparam logic [7:0] APP_CPU_ID_RESET = 8'h11;
  localparam logic [7:0] APP_DMA_ID_RESET = 8'h12;

  // Processor self-reset pulse length.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SELF_RESET_NS = 100;
  localparam int SELF_RESET_CYCLES = (SELF_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COUNT_W = 8;

  typedef enum logic [1:0] {
    serial_load_mode,
    func_two_wire_debug_mode,
    func_four_wire_debug_mode
  } bmss_mode_t;

  typedef enum {
    ST_POR_HOLD,
    ST_ROM_ENTRY,
    ST_INIT_BOOT,
    ST_SELF_RESET,
    ST_UNSECURE_BOOT,
    ST_APP_RUN,
    ST_SERIAL_LOAD
  } bmss_state_t;

  // Maps a latched strap value to a boot mode; unlisted codes fall back to four-wire.
  function automatic bmss_mode_t decode_mode(input logic [2:0] strap);
    bmss_mode_t m;
    m = func_four_wire_debug_mode;
    if (strap == STRAP_SERIAL_LOAD) begin
      m = serial_load_mode;
    end else if (strap == STRAP_TWO_WIRE) begin
      m = func_two_wire_debug_mode;
    end
    return m;
  endfunction

  // True for an address inside the secure region.
  function automatic logic is_secure(input logic [7:0] addr);
    return (addr >= SECURE_FIRST) && (addr <= SECURE_LAST);
  endfunction

endpackage

/* File: tb/bmss_strap_board.sv */
// Board model: strap pulls on the three power-up pins, and the application reusing pin two.
// Assumes rstn is the power-on reset and the bench sets strapCode before releasing it.
`timescale 1ns/1ns
`default_nettype none

module bmss_strap_board (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2:0] strapCode,
  output logic [2:0] powerUpStrapBits
);
  logic [3:0] upCount;
  logic pinTwoOut;

  // Counts cycles after power-up, so that pin two is only reused once power-up is over.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      upCount <= 4'h0;
      pinTwoOut <= 1'b0;
    end else begin
      if (upCount != 4'hF) begin
        upCount <= upCount + 4'h1;
      end
      pinTwoOut <= ~pinTwoOut;
    end
  end

  // pin two output
  // Pins zero and one only ever carry their pull level; pin two becomes an output
  // that changes every cycle once power-up is over, so any resampling shows.
  assign powerUpStrapBits = {((upCount >= 4'h4) ? pinTwoOut : strapCode[2]), strapCode[1:0]};
endmodule
`default_nettype wire

/* File: tb/test_boot_mode_secure_sequencer.sv */
// Self-checking bench of the boot mode secure sequencer beside a board strap model.
// Assumes a 100 MHz clock and a shortened processor self-reset pulse.
`timescale 1ns/1ns
`default_nettype none

`define CHECK(what, exp, got) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD %s expected %h seen %h", what, exp, got); end end

module test_boot_mode_secure_sequencer;
  localparam int SR_CYCLES = 3;
  localparam int LIMIT = 5000;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] strapCode = 3'h0;
  logic [2:0] powerUpStrapBits;
  logic [7:0] address = 8'h00;
  logic [31:0] writeData = 32'h0000_0000;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic [31:0] readData;
  logic [31:0] got;
  logic cpuResetn, initBootActive, secureOpen, appRunning, serialLoadActive, secureViolation;
  logic [7:0] cpuMasterId, dmaMasterId;
  logic jtagFourWireEn, swdTwoWireEn, uartLoadEn;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  // Free-running clock, 10 ns period.
  always #5 clock = ~clock;

  bmss_strap_board bmss_strap_board_i (.clock(clock), .rstn(rstn), .strapCode(strapCode),
    .powerUpStrapBits(powerUpStrapBits));

  bmss_sequencer #(.SELF_RESET_CYCLES(SR_CYCLES)) bmss_sequencer_i (.clock(clock), .rstn(rstn),
    .powerUpStrapBits(powerUpStrapBits), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .cpuResetn(cpuResetn),
    .initBootActive(initBootActive), .secureOpen(secureOpen), .appRunning(appRunning),
    .serialLoadActive(serialLoadActive), .secureViolation(secureViolation),
    .cpuMasterId(cpuMasterId), .dmaMasterId(dmaMasterId), .jtagFourWireEn(jtagFourWireEn),
    .swdTwoWireEn(swdTwoWireEn), .uartLoadEn(uartLoadEn));

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      finish_test();
    end
  end

  // One-cycle write; the effect is sampled just after the taking edge.
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    writeStrobe <= 1'b1;
    address <= a;
    writeData <= d;
    @(posedge clock);
    writeStrobe <= 1'b0;
    #1;
  endtask

  // One-cycle read; data are taken in the single cycle they stand.
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    readStrobe <= 1'b1;
    address <= a;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask

  // Expected status word; secure access and flag go together.
  function automatic logic [31:0] status_word(input logic [2:0] code, input logic [3:0] st,
    input logic flag);
    logic [1:0] mode;
    mode = (code == 3'h4) ? 2'h0 : ((code == 3'h1) ? 2'h1 : 2'h2);
    return {18'h0, mode, 1'b0, 1'b1, flag, flag, st, 1'b0, code};
  endfunction

  // Power cycle with a strap code, then check the init pass and the pin mapping.
  task automatic power_up(input logic [2:0] code);
    @(posedge clock);
    rstn <= 1'b0;
    strapCode <= code;
    repeat (2) @(posedge clock);
    #1;
    `CHECK("reset cpu id", 8'h01, cpuMasterId)
    `CHECK("reset hold", 1'b0, cpuResetn)
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    `CHECK("init active", 1'b1, initBootActive)
    `CHECK("secure open", 1'b1, secureOpen)
    `CHECK("four wire map", (code != 3'h1), jtagFourWireEn)
    `CHECK("two wire map", (code == 3'h1), swdTwoWireEn)
    `CHECK("uart map", (code == 3'h4), uartLoadEn)
    reg_read(bmss_pkg::REG_STATUS, got);
    `CHECK("init status", status_word(code, 4'h2, 1'b1), got)
  endtask

  // Secure region is open during init.
  task automatic check_init_pass();
    reg_read(bmss_pkg::REG_INIT_FLAG, got);
    `CHECK("first boot flag", 32'h0000_0001, got)
    reg_write(bmss_pkg::REG_SCRATCH, 32'hA5A5_5A5A);
    reg_read(bmss_pkg::REG_SCRATCH, got);
    `CHECK("init scratch", 32'hA5A5_5A5A, got)
    reg_write(bmss_pkg::REG_CPU_ID, 32'h0000_0033);
    reg_write(bmss_pkg::REG_DMA_ID, 32'h0000_0044);
    reg_read(bmss_pkg::REG_DMA_ID, got);
    `CHECK("init dma id reg", 32'h0000_0044, got)
    `CHECK("init cpu id", 8'h01, cpuMasterId)
    reg_read(bmss_pkg::REG_BLOCKED, got);
    `CHECK("nothing blocked", 32'h0000_0000, got)
  endtask

  // Software may clear the first-boot flag during init but never set it again.
  task automatic check_flag_clear();
    reg_write(bmss_pkg::REG_INIT_FLAG, 32'h0000_0000);
    `CHECK("flag cleared id", 8'h11, cpuMasterId)
    reg_write(bmss_pkg::REG_INIT_FLAG, 32'h0000_0001);
    reg_read(bmss_pkg::REG_INIT_FLAG, got);
    `CHECK("flag not set", 32'h0000_0000, got)
  endtask

  // Ends init, measures the self reset and checks the second boot.
  task automatic self_reset(input logic [2:0] code, input logic [7:0] cpuId, input logic [7:0] dmaId);
    int cnt;
    cnt = 0;
    reg_write(bmss_pkg::REG_CONTROL, 32'h0000_0001);
    `CHECK("leave init", 1'b0, initBootActive | secureOpen)
    `CHECK("app cpu id", cpuId, cpuMasterId)
    `CHECK("app dma id", dmaId, dmaMasterId)
    while (cpuResetn === 1'b0 && cnt < 300) begin
      @(posedge clock);
      #1;
      cnt++;
    end
    `CHECK("self reset length", SR_CYCLES, cnt)
    if (code == 3'h4) begin
      @(posedge clock);
      #1;
      `CHECK("serial load wait", 1'b1, serialLoadActive)
    end else begin
      reg_read(bmss_pkg::REG_STATUS, got);
      `CHECK("second boot status", status_word(code, 4'h4, 1'b0), got)
    end
  endtask

  // Locked secure region, blocked counts and the move to the application.
  task automatic check_app();
    reg_read(bmss_pkg::REG_SCRATCH, got);
    `CHECK("locked read", 32'h0000_0000, got)
    `CHECK("violation on read", 1'b1, secureViolation)
    reg_write(bmss_pkg::REG_CPU_ID, 32'h0000_0077);
    `CHECK("violation on write", 1'b1, secureViolation)
    reg_read(bmss_pkg::REG_BLOCKED, got);
    `CHECK("blocked count", 32'h0000_0002, got)
    `CHECK("no violation", 1'b0, secureViolation)
    `CHECK("locked id", 8'h33, cpuMasterId)
    reg_write(bmss_pkg::REG_CONTROL, 32'h0000_0001);
    `CHECK("no second self reset", 1'b1, cpuResetn)
    reg_write(bmss_pkg::REG_CONTROL, 32'h0000_0002);
    `CHECK("app running", 1'b1, appRunning)
    reg_write(bmss_pkg::REG_STATUS, 32'hFFFF_FFFF);
    reg_read(bmss_pkg::REG_STATUS, got);
    `CHECK("app status", status_word(3'h1, 4'h5, 1'b0), got)
    reg_read(8'hFC, got);
    `CHECK("unmapped read", 32'h0000_0000, got)
  endtask

  // Serial load waits and ignores the boot-done request.
  task automatic check_serial_load();
    power_up(3'h4);
    self_reset(3'h4, 8'h11, 8'h12);
    reg_write(bmss_pkg::REG_CONTROL, 32'h0000_0002);
    repeat (200) @(posedge clock);
    #1;
    `CHECK("still waiting", 1'b1, serialLoadActive)
    `CHECK("no app", 1'b0, appRunning)
    `CHECK("load map", 1'b1, uartLoadEn)
    `CHECK("load jtag map", 1'b1, jtagFourWireEn)
  endtask

  // Main sequence; each new power-up is the host re-strapping the board.
  initial begin
    power_up(3'h1);
    check_init_pass();
    self_reset(3'h1, 8'h33, 8'h44);
    check_app();
    check_serial_load();
    power_up(3'h0);
    check_flag_clear();
    self_reset(3'h0, 8'h11, 8'h12);
    finish_test();
  end
endmodule
`default_nettype wire
